// ==== tb/dcbd_chk.sv ====
// Port checker for the control byte decoder
`timescale 1ns/100ps
`default_nettype none
module dcbd_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // I2C side
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  // Channel registers
  input wire logic [13:0] tempA,
  input wire logic [13:0] tempB,
  input wire logic [13:0] tempC,
  input wire logic [13:0] tempD,
  input wire logic [13:0] convA,
  input wire logic [13:0] convB,
  input wire logic [13:0] convC,
  input wire logic [13:0] convD,
  input wire logic updatePulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles since the acknowledge drive was let go, saturating
  logic [4:0] sinceAck_ff;
  wire [55:0] temps = {tempA, tempB, tempC, tempD};
  wire [55:0] convs = {convA, convB, convC, convD};
  always_ff @(posedge clk) begin
    if (!nrst || !sdaOe_n) sinceAck_ff <= 5'h00;
    else if (sinceAck_ff != 5'h1f) sinceAck_ff <= sinceAck_ff + 5'h01;
  end
  sequence s_ackOn;
    $fell(sdaOe_n);
  endsequence
  sequence s_ackOff;
    ##[1:20] sdaOe_n;
  endsequence
  a_pulse_one: assert property (updatePulse |=> !updatePulse)
    else $error("update pulse longer than one cycle");
  a_pulse_after_ack: assert property (updatePulse |-> sinceAck_ff < 5'h10)
    else $error("update without a recent acknowledge");
  a_conv_hold: assert property (!$past(updatePulse) |-> $stable(convs))
    else $error("converter register moved without update");
  a_temp_hold: assert property (!$past(updatePulse) |-> $stable(temps))
    else $error("temporary register moved without update");
  a_conv_from_temp: assert property ($past(updatePulse) |->
    (convA == tempA || $stable(convA)) && (convB == tempB || $stable(convB)) &&
    (convC == tempC || $stable(convC)) && (convD == tempD || $stable(convD)))
    else $error("converter loaded with a value not in its temporary register");
  a_ack_low: assert property (!sdaOe_n |-> !sdaOut)
    else $error("data driven high");
  a_ack_hold: assert property ($rose(sclIn) && !sdaOe_n |-> !sdaOe_n [*4])
    else $error("acknowledge dropped while clock high");
  a_ack_release: assert property (s_ackOn |-> s_ackOff)
    else $error("acknowledge held too long");
endmodule
`default_nettype wire

// ==== tb/dcbd_i2c_master.sv ====
// Bus master model making the serial clock and data
`timescale 1ns/100ps
`default_nettype none
module dcbd_i2c_master (
  // Bus lines, data released means pulled high
  output var logic scl,
  output var logic sdaDrv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Data moves mid low phase so start and stop are never mistaken
  task automatic start();
    #50 sdaDrv = 1'b1;
    #50 scl = 1'b1;
    #100 sdaDrv = 1'b0;
    #100 scl = 1'b0;
  endtask
  task automatic stop();
    #50 sdaDrv = 1'b0;
    #50 scl = 1'b1;
    #100 sdaDrv = 1'b1;
    #100;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #50 sdaDrv = b[i];
      #50 scl = 1'b1;
      #100 scl = 1'b0;
    end
    #50 sdaDrv = 1'b1;
    #50 scl = 1'b1;
    #50 ack = !sda;
    #50 scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench for the control byte decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, nrst, pinHi, pinLo, ext3, ext2, ack;
  wire scl, sdaDrv, sdaOut, sdaOe_n, updatePulse;
  wire [13:0] tempA, tempB, tempC, tempD, convA, convB, convC, convD;
  wire sda = sdaDrv & (sdaOe_n | sdaOut);
  logic [13:0] t[4], c[4];
  logic [111:0] expQ[$];
  int err_total = 0, n_compared = 0, seed = 23313;
  dcbd_decoder DUT (.clk(clk), .nrst(nrst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .addrSelectPinHi(pinHi), .addrSelectPinLo(pinLo), .extAddrPin3(ext3),
    .extAddrPin2(ext2), .tempA(tempA), .tempB(tempB), .tempC(tempC), .tempD(tempD),
    .convA(convA), .convB(convB), .convC(convC), .convD(convD), .updatePulse(updatePulse));
  dcbd_i2c_master M (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [111:0] e, input logic [111:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Registers reach the ports one clock after the pulse; sampled mid-cycle
  always @(negedge clk) begin
    if (updatePulse === 1'b1) begin
      @(negedge clk);
      if (expQ.size() == 0) chk("spurious update", 0, 1);
      else chk("regs", expQ.pop_front(),
        {tempA, tempB, tempC, tempD, convA, convB, convC, convD});
    end
  end
  task automatic send(input logic [7:0] b, input logic expAck);
    M.wbyte(b, ack);
    chk("ack", expAck, ack);
  endtask
  task automatic pair(input logic [7:0] cmd);
    logic [7:0] up, lo;
    logic [13:0] d;
    up = 8'($random(seed));
    lo = 8'($random(seed));
    d = cmd[0] ? {up[7:6], 12'h000} : {2'b00, up, lo[7:4]};
    send(up, 1'b1);
    send(lo, 1'b1);
    if (cmd[5:4] == 2'h3) begin
      for (int i = 0; i < 4; i++) begin
        if (cmd[2]) t[i] = d;
        c[i] = t[i];
      end
    end else if (cmd[7:6] == {ext3, ext2}) begin
      t[cmd[2:1]] = d;
      if (cmd[4]) c[cmd[2:1]] = d;
      for (int i = 0; i < 4; i++) if (cmd[5]) c[i] = t[i];
    end
    if (cmd[5:4] == 2'h3 || cmd[7:6] == {ext3, ext2}) expQ.push_back({t[0], t[1], t[2], t[3],
      c[0], c[1], c[2], c[3]});
  endtask
  task automatic xfer(input logic [7:0] addr, input logic [7:0] cmd, input int n);
    M.start();
    send(addr, 1'b1);
    send(cmd, 1'b1);
    repeat (n) pair(cmd);
    M.stop();
  endtask
  initial begin
    nrst = 1'b0;
    {pinHi, pinLo} = 2'b01;
    {ext3, ext2} = 2'b10;
    foreach (t[i]) {t[i], c[i]} = 28'h0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    for (int k = 0; k < 24; k++) xfer(8'h9a, {2'b10, k[4:3], 1'b0, k[2:1], k[0]}, 1);
    $display("test modes done");
    xfer(8'h90, 8'h34, 1);
    xfer(8'h9a, 8'h84, 2);
    xfer(8'h9a, 8'h31, 1);
    xfer(8'h9a, 8'h52, 1);
    $display("test broadcast done");
    M.start();
    send(8'h91, 1'b0);
    M.stop();
    M.start();
    send(8'h9c, 1'b0);
    M.stop();
    repeat (20) @(posedge clk);
    #1;
    chk("pending", 0, expQ.size());
    chk("final", {t[0], t[1], t[2], t[3], c[0], c[1], c[2], c[3]},
      {tempA, tempB, tempC, tempD, convA, convB, convC, convD});
    $display("test refusals done");
    stop_test();
  end
  initial begin
    #1000000;
    err_total++;
    stop_test();
  end
endmodule
bind dcbd_decoder dcbd_chk u_chk (.clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe_n(sdaOe_n), .tempA(tempA), .tempB(tempB), .tempC(tempC), .tempD(tempD),
  .convA(convA), .convB(convB), .convC(convC), .convD(convD), .updatePulse(updatePulse));
`default_nettype wire

// ==== verilog/dcbd_decoder.v ====
// I2C slave front end and control byte decoder of a quad 12-bit converter
// Functional notes
// - Acknowledge broadcast address regardless of address select pins, plus own address
// - Broadcast address valid for writes only; never answer a broadcast read
// - Broadcast transfers let several converters update or power down together
// - Control byte: ext addr 2 bits, load 2, ignored, select 2, power-down flag
// - Update only when ext address bits match pins, unless broadcast mode
// - Load mode 00 writes only the selected temporary register
// - Load mode 01 writes temporary and converter register of selected channel
// - Load mode 10 writes selected channel, loads others from temporary
// - Load mode 11 ignores address match and the low select bit, updates all
// - Mode 11 with select-high clear loads all converters from temporary registers
// - Mode 11 with select-high set loads new data or power-down to all
// - Power-down flag set makes upper byte top two bits a power-down code
// - Update happens at falling edge of acknowledge clock after lower byte
// - Control byte stays in force for further byte pairs in a transfer
// - Own address is 10011, two latched select pins, then read/write bit
`timescale 1ns/100ps
`default_nettype none
`include "dcbd_defs.vh"
module dcbd_decoder (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // I2C pins, open drain data
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe_n,
  // Address straps
  input wire addrSelectPinHi,
  input wire addrSelectPinLo,
  input wire extAddrPin3,
  input wire extAddrPin2,
  // Channel registers, power-down code in bits 13:12
  output reg [13:0] tempA,
  output reg [13:0] tempB,
  output reg [13:0] tempC,
  output reg [13:0] tempD,
  output reg [13:0] convA,
  output reg [13:0] convB,
  output reg [13:0] convC,
  output reg [13:0] convD,
  output reg updatePulse
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_SKIP = 2'h3;
  // Byte slots within a write transfer
  localparam SLOT_CMD = 2'h0;
  localparam SLOT_UPPER = 2'h1;
  localparam SLOT_LOWER = 2'h2;

  reg [2:0] sclSync_ff;
  reg [2:0] sdaSync_ff;
  reg [3:0] strapSync_ff;
  reg [3:0] strapMeta_ff;
  reg [1:0] addrLatch_ff;
  reg strapDone_ff;
  reg [1:0] state_ff;
  reg [3:0] bitCnt_ff;
  reg [7:0] shift_ff;
  reg [1:0] byteIdx_ff;
  reg [7:0] command_byte_ff;
  reg [7:0] upperByte_ff;
  reg [7:0] lowerByte_ff;
  reg ackArm_ff;
  reg doUpdate_ff;
  reg [13:0] tempReg_ff [0:3];
  reg [13:0] convReg_ff [0:3];

  wire sclS = sclSync_ff[1];
  wire sdaS = sdaSync_ff[1];
  wire sclRise = sclSync_ff[1] & ~sclSync_ff[2];
  wire sclFall = ~sclSync_ff[1] & sclSync_ff[2];
  wire startCond = sclS & sclSync_ff[2] & ~sdaS & sdaSync_ff[2];
  wire stopCond = sclS & sclSync_ff[2] & sdaS & ~sdaSync_ff[2];
  wire [7:0] rxByte = {shift_ff[6:0], sdaS};
  wire [7:0] ownAddr = {`DCBD_OWN_ADDR_TOP, addrLatch_ff, 1'b0};
  // Own address write, or broadcast write; broadcast read never matches
  wire addrHit = (rxByte == ownAddr) || (rxByte == `DCBD_BCAST_ADDR);
  // Bit slots of the byte engine
  wire lastBit = (bitCnt_ff == 4'h7);
  wire ackSlot = (bitCnt_ff == 4'h8);

  // Straps synchronized every clock, reset or not; select pins latched only after reset release
  always @(posedge clk) begin
    strapMeta_ff <= {extAddrPin3, extAddrPin2, addrSelectPinHi, addrSelectPinLo};
    strapSync_ff <= strapMeta_ff;
    sclSync_ff <= {sclSync_ff[1:0], sclIn};
    sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
  end

  always @(posedge clk) begin
    if (!nrst) begin
      addrLatch_ff <= 2'h0;
      strapDone_ff <= 1'b0;
    end else if (!strapDone_ff) begin
      addrLatch_ff <= strapSync_ff[1:0];
      strapDone_ff <= 1'b1;
    end
  end

  // Byte engine: bitCnt 0..7 data bits, 8 is the acknowledge slot
  always @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byteIdx_ff <= 2'h0;
      command_byte_ff <= `DCBD_CMD_RESET;
      upperByte_ff <= 8'h00;
      lowerByte_ff <= 8'h00;
      ackArm_ff <= 1'b0;
      doUpdate_ff <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe_n <= 1'b1;
    end else begin
      doUpdate_ff <= 1'b0;
      if (startCond) begin
        state_ff <= ST_ADDR;
        // First fall after a start ends the start, not a data bit
        bitCnt_ff <= 4'hf;
        ackArm_ff <= 1'b0;
        sdaOe_n <= 1'b1;
      end else if (stopCond) begin
        state_ff <= ST_IDLE;
        ackArm_ff <= 1'b0;
        sdaOe_n <= 1'b1;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            bitCnt_ff <= 4'h0;
          end
          ST_ADDR, ST_DATA: begin
            if (sclRise && bitCnt_ff < 4'h8) begin
              shift_ff <= rxByte;
              if (lastBit) begin
                if (state_ff == ST_ADDR) begin
                  ackArm_ff <= addrHit;
                  byteIdx_ff <= SLOT_CMD;
                end else begin
                  ackArm_ff <= 1'b1;
                  case (byteIdx_ff)
                    SLOT_CMD: command_byte_ff <= rxByte;
                    SLOT_UPPER: upperByte_ff <= rxByte;
                    default: lowerByte_ff <= rxByte;
                  endcase
                end
              end
            end
            if (sclFall) begin
              if (lastBit) begin
                bitCnt_ff <= 4'h8;
                sdaOe_n <= ~ackArm_ff;
                sdaOut <= 1'b0;
              end else if (ackSlot) begin
                bitCnt_ff <= 4'h0;
                sdaOe_n <= 1'b1;
                if (!ackArm_ff) begin
                  state_ff <= ST_SKIP;
                end else if (state_ff == ST_ADDR) begin
                  state_ff <= ST_DATA;
                end else begin
                  // Command kept; further pairs alternate upper and lower
                  if (byteIdx_ff == SLOT_LOWER) begin
                    byteIdx_ff <= SLOT_UPPER;
                    doUpdate_ff <= 1'b1;
                  end else begin
                    byteIdx_ff <= byteIdx_ff + 2'h1;
                  end
                end
                ackArm_ff <= 1'b0;
              end else begin
                // Also wraps the post-start wait value to bit zero
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end
            end
          end
          ST_SKIP: begin
            sdaOe_n <= 1'b1;
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Decode of the stored command byte
  wire [1:0] loadMode = {command_byte_ff[`DCBD_LOAD_HI_BIT],
    command_byte_ff[`DCBD_LOAD_LO_BIT]};
  wire [1:0] chanSel = {command_byte_ff[`DCBD_SEL_HI_BIT],
    command_byte_ff[`DCBD_SEL_LO_BIT]};
  wire pdFlag = command_byte_ff[`DCBD_PD_BIT];
  wire extMatch = (command_byte_ff[`DCBD_EXT3_BIT] == strapSync_ff[3]) &&
    (command_byte_ff[`DCBD_EXT2_BIT] == strapSync_ff[2]);
  wire isBcast = (loadMode == `DCBD_LOAD_BCAST);
  wire updOk = extMatch || isBcast;
  // Power-down code replaces data when the flag is set
  wire [13:0] newWord = pdFlag ? {upperByte_ff[7:6], 12'h000} :
    {2'b00, upperByte_ff, lowerByte_ff[7:4]};
  // Update fires when the extended address test passes or in broadcast mode
  wire updFire = doUpdate_ff && updOk;

  // Channel select compare, shared by load modes 00, 01 and 10
  function selHit;
    input [1:0] sel;
    input [1:0] ch;
    begin
      selHit = (sel == ch);
    end
  endfunction

  // Per-channel enables of one update
  reg [3:0] tempWe;
  reg [3:0] convWe;
  reg [3:0] convCopy;
  integer j;
  always @* begin
    tempWe = 4'h0;
    convWe = 4'h0;
    convCopy = 4'h0;
    for (j = 0; j < 4; j = j + 1) begin
      case (loadMode)
        `DCBD_LOAD_TEMP: begin
          tempWe[j] = selHit(chanSel, j[1:0]);
        end
        `DCBD_LOAD_ONE: begin
          tempWe[j] = selHit(chanSel, j[1:0]);
          convWe[j] = selHit(chanSel, j[1:0]);
        end
        `DCBD_LOAD_ALL: begin
          tempWe[j] = selHit(chanSel, j[1:0]);
          convWe[j] = selHit(chanSel, j[1:0]);
          convCopy[j] = ~selHit(chanSel, j[1:0]);
        end
        default: begin
          // All channels, for synchronous multi-device updates; low select bit unused
          tempWe[j] = chanSel[1];
          convWe[j] = chanSel[1];
          convCopy[j] = ~chanSel[1];
        end
      endcase
    end
  end

  integer i;
  always @(posedge clk) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        tempReg_ff[i] <= `DCBD_REG_RESET;
        convReg_ff[i] <= `DCBD_REG_RESET;
      end
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= updFire;
      if (updFire) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (tempWe[i]) begin
            tempReg_ff[i] <= newWord;
          end
          // Copy takes the temporary word from before this edge
          if (convWe[i]) begin
            convReg_ff[i] <= newWord;
          end else if (convCopy[i]) begin
            convReg_ff[i] <= tempReg_ff[i];
          end
        end
      end
    end
  end

  // Ports mirror the arrays one clock late so each comes from a flip-flop
  always @(posedge clk) begin
    if (!nrst) begin
      tempA <= `DCBD_REG_RESET;
      tempB <= `DCBD_REG_RESET;
      tempC <= `DCBD_REG_RESET;
      tempD <= `DCBD_REG_RESET;
      convA <= `DCBD_REG_RESET;
      convB <= `DCBD_REG_RESET;
      convC <= `DCBD_REG_RESET;
      convD <= `DCBD_REG_RESET;
    end else begin
      tempA <= tempReg_ff[0];
      tempB <= tempReg_ff[1];
      tempC <= tempReg_ff[2];
      tempD <= tempReg_ff[3];
      convA <= convReg_ff[0];
      convB <= convReg_ff[1];
      convC <= convReg_ff[2];
      convD <= convReg_ff[3];
    end
  end
endmodule
`default_nettype wire

// ==== verilog/dcbd_defs.vh ====
// Constants for the converter control byte decoder
`ifndef DCBD_DEFS_VH
`define DCBD_DEFS_VH
`define DCBD_OWN_ADDR_TOP 5'h13
`define DCBD_BCAST_ADDR 8'h90
`define DCBD_EXT3_BIT 7
`define DCBD_EXT2_BIT 6
`define DCBD_LOAD_HI_BIT 5
`define DCBD_LOAD_LO_BIT 4
`define DCBD_SEL_HI_BIT 2
`define DCBD_SEL_LO_BIT 1
`define DCBD_PD_BIT 0
`define DCBD_LOAD_TEMP 2'h0
`define DCBD_LOAD_ONE 2'h1
`define DCBD_LOAD_ALL 2'h2
`define DCBD_LOAD_BCAST 2'h3
`define DCBD_CMD_RESET 8'h00
`define DCBD_REG_RESET 14'h0000
`endif
